// File: verilog/pch_cfg_regs.sv
// Command, status, class code and capability configuration registers
`timescale 1ns/10ps
module pch_cfg_regs #(
   parameter bit B2B_SUPPORT = 1'b0
) (
   input  wire logic                        CORE_CLK_I,
   input  wire logic                        NRST_I,
   input  wire logic                        CE_I,
   input  wire logic                        CFG_SEL_I,
   input  wire logic                        CFG_WR_I,
   input  wire logic [pch_pkg::IDX_W+1:2]   CFG_ADDR_I,
   input  wire logic [3:0]                  CFG_BE_I,
   input  wire logic [31:0]                 CFG_WDATA_I,
   input  wire logic                        PM_D0_I,
   input  wire logic                        ROM_WINDOW_ENABLE_I,
   input  wire logic                        MST_ACTIVE_I,
   input  wire logic                        PERR_N_I,
   input  wire logic                        TGT_ABORT_SENT_I,
   input  wire logic                        MST_TGT_ABORT_I,
   input  wire logic                        MST_MASTER_ABORT_I,
   input  wire logic                        PAR_ERR_DET_I,
   input  wire logic                        SERR_REQ_I,
   output logic      [31:0]                 CFG_RDATA_O,
   output logic                             CFG_ACK_O,
   output logic                             IO_DECODE_ENABLE_O,
   output logic                             MEM_DECODE_ENABLE_O,
   output logic                             ROM_DECODE_ENABLE_O,
   output logic                             MASTER_INITIATE_ENABLE_O,
   output logic                             WRITE_INVALIDATE_PERMIT_O,
   output logic                             PARITY_REPORT_O,
   output logic                             SYSERR_DRIVE_O
);
   import pch_pkg::*;

   logic [15:0]       cmd;
   logic [15:0]       next_cmd;
   logic              perr_n_seen;
   wire  [15:0]       stat_word;
   wire  [31:0]       rd_word;
   wire  [IDX_W-1:0]  idx;
   wire               hit_cmd;
   wire               hit_class;
   wire               hit_head;
   wire               hit_type;
   wire               cfg_wr;
   wire               cfg_rd;
   wire               wr_cmd;
   wire               perr_seen;

   pch_evt_if #(.N(EVT_N)) evt ();

   pch_pin_sync #(
      .W       (1),
      .RST_VAL (1'b1)
   ) u_perr_sync (
      .clk_i   (CORE_CLK_I),
      .rst_n_i (NRST_I),
      .ce_i    (CE_I),
      .pin_i   (PERR_N_I),
      .val_o   (perr_n_seen)
   );

   pch_evt_flags u_flags (
      .clk_i   (CORE_CLK_I),
      .rst_n_i (NRST_I),
      .ce_i    (CE_I),
      .ev      (evt.owner)
   );

   // Address decode
   assign idx       = CFG_ADDR_I;
   assign hit_cmd   = (idx == OFS_CMD[IDX_W+1:2]);
   assign hit_class = (idx == OFS_CLASS[IDX_W+1:2]);
   assign hit_head  = (idx == OFS_CAP_HEAD[IDX_W+1:2]);
   assign hit_type  = (idx == OFS_CAP_TYPE[IDX_W+1:2]);
   assign cfg_wr    = CFG_SEL_I & CFG_WR_I;
   assign cfg_rd    = CFG_SEL_I & ~CFG_WR_I;
   assign wr_cmd    = cfg_wr & hit_cmd;
   assign perr_seen = ~perr_n_seen;

   // Reserved command bits are masked off before storage
   assign next_cmd[7:0]  = CFG_BE_I[0] ?
                           (CFG_WDATA_I[7:0] & CMD_MASK[7:0]) :
                           cmd[7:0];
   assign next_cmd[15:8] = CFG_BE_I[1] ?
                           (CFG_WDATA_I[15:8] & CMD_MASK[15:8]) :
                           cmd[15:8];

   // Status word
   assign stat_word[3:0]          = 4'h0;
   assign stat_word[ST_CAP]       = 1'b1;
   assign stat_word[ST_66]        = 1'b1;
   assign stat_word[6]            = 1'b0;
   assign stat_word[ST_B2B]       = B2B_SUPPORT;
   assign stat_word[ST_SEL+1:ST_SEL] = SEL_SPEED;

   for (genvar i = 0; i < EVT_N; i++) begin : g_evt
      assign stat_word[EV_POS[i]] = evt.flag[i];
      assign evt.clr[i] = wr_cmd & CFG_BE_I[3] &
                          CFG_WDATA_I[16+EV_POS[i]];
   end

   // Event sources
   assign evt.set[EV_MPAR]    = MST_ACTIVE_I & perr_seen &
                                cmd[CMD_PAR];
   assign evt.set[EV_TA_SENT] = TGT_ABORT_SENT_I;
   assign evt.set[EV_TA_SEEN] = MST_TGT_ABORT_I;
   assign evt.set[EV_MA_SEEN] = MST_MASTER_ABORT_I;
   assign evt.set[EV_SERR]    = SYSERR_DRIVE_O;
   assign evt.set[EV_PERR]    = PAR_ERR_DET_I;

   // Read mux; anything not decoded reads zero
   assign rd_word = hit_cmd   ? {stat_word, cmd} :
                    hit_class ? {CLASS_VAL, 8'h00} :
                    hit_head  ? {24'h000000, OFS_CAP_TYPE} :
                    hit_type  ? {24'h000000, CAP_TYPE_VAL} :
                    32'h00000000;

   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         cmd <= CMD_RESET;
      end else if (CE_I && wr_cmd) begin
         cmd <= next_cmd;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         CFG_RDATA_O <= 32'h00000000;
         CFG_ACK_O   <= 1'b0;
      end else if (CE_I) begin
         CFG_ACK_O   <= CFG_SEL_I;
         CFG_RDATA_O <= cfg_rd ? rd_word : 32'h00000000;
      end
   end

   // Every enable drops out while command is zero
   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         IO_DECODE_ENABLE_O        <= 1'b0;
         MEM_DECODE_ENABLE_O       <= 1'b0;
         ROM_DECODE_ENABLE_O       <= 1'b0;
         MASTER_INITIATE_ENABLE_O  <= 1'b0;
         WRITE_INVALIDATE_PERMIT_O <= 1'b0;
      end else if (CE_I) begin
         IO_DECODE_ENABLE_O        <= cmd[CMD_IO] & PM_D0_I;
         MEM_DECODE_ENABLE_O       <= cmd[CMD_MEM] & PM_D0_I;
         ROM_DECODE_ENABLE_O       <= cmd[CMD_MEM] & ROM_WINDOW_ENABLE_I &
                                      PM_D0_I;
         MASTER_INITIATE_ENABLE_O  <= cmd[CMD_MST] & PM_D0_I;
         WRITE_INVALIDATE_PERMIT_O <= cmd[CMD_MWI];
      end
   end

   // Error outputs are gated so a disabled path stays quiet
   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         PARITY_REPORT_O <= 1'b0;
         SYSERR_DRIVE_O  <= 1'b0;
      end else if (CE_I) begin
         PARITY_REPORT_O <= PAR_ERR_DET_I & cmd[CMD_PAR];
         SYSERR_DRIVE_O  <= SERR_REQ_I & cmd[CMD_SERR];
      end
   end

   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!NRST_I);

   sequence s_rd(logic hit);
      CE_I && cfg_rd && hit;
   endsequence

   sequence s_stat_clr(int pos);
      CE_I && wr_cmd && CFG_BE_I[3] && CFG_WDATA_I[16+pos];
   endsequence

   property p_cap_type;
      s_rd(hit_type) |=> CFG_ACK_O && CFG_RDATA_O == 32'h00000001;
   endproperty
   a_cap_type: assert property (p_cap_type)
      else $error("capability type did not read 0x01");

   property p_cap_head;
      s_rd(hit_head) |=> CFG_RDATA_O == 32'h00000050;
   endproperty
   a_cap_head: assert property (p_cap_head)
      else $error("capability list head did not read 0x50");

   property p_class;
      s_rd(hit_class) |=> CFG_RDATA_O == 32'h02000000;
   endproperty
   a_class: assert property (p_class)
      else $error("function category wrong");

   property p_cmd_reset;
      $rose(NRST_I) |-> cmd == 16'h0000 && !IO_DECODE_ENABLE_O;
   endproperty
   a_cmd_reset: assert property (p_cmd_reset)
      else $error("command not zero after reset");

   property p_cmd_zero;
      (CE_I && cmd == 16'h0000) |=> !(IO_DECODE_ENABLE_O ||
         MEM_DECODE_ENABLE_O || ROM_DECODE_ENABLE_O ||
         MASTER_INITIATE_ENABLE_O);
   endproperty
   a_cmd_zero: assert property (p_cmd_zero)
      else $error("bus enable active with zero command");

   property p_io;
      CE_I |=> IO_DECODE_ENABLE_O == $past(cmd[0] && PM_D0_I);
   endproperty
   a_io: assert property (p_io)
      else $error("I/O decode enable wrong");

   property p_rom;
      CE_I |=> ROM_DECODE_ENABLE_O ==
         $past(cmd[1] && ROM_WINDOW_ENABLE_I && PM_D0_I);
   endproperty
   a_rom: assert property (p_rom)
      else $error("ROM decode enable wrong");

   property p_mst;
      (CE_I && !(cmd[2] && PM_D0_I)) |=> !MASTER_INITIATE_ENABLE_O;
   endproperty
   a_mst: assert property (p_mst)
      else $error("mastering allowed without bit 2 in D0");

   property p_mwi;
      CE_I |=> WRITE_INVALIDATE_PERMIT_O == $past(cmd[4]);
   endproperty
   a_mwi: assert property (p_mwi)
      else $error("write-invalidate permit wrong");

   property p_par;
      CE_I |=> PARITY_REPORT_O == $past(PAR_ERR_DET_I && cmd[6]);
   endproperty
   a_par: assert property (p_par)
      else $error("parity reaction not gated by bit 6");

   property p_serr;
      (CE_I && !cmd[8]) |=> !SYSERR_DRIVE_O;
   endproperty
   a_serr: assert property (p_serr)
      else $error("system error asserted while disabled");

   property p_reserved;
      (cmd & 16'hFEA8) == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved command bit stored");

   property p_w1c;
      (s_stat_clr(11) ##0 !TGT_ABORT_SENT_I) |=> !stat_word[11];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("written one did not clear status bit");

   property p_w0_keeps;
      (CE_I && wr_cmd && !CFG_WDATA_I[29] && stat_word[13])
         |=> stat_word[13];
   endproperty
   a_w0_keeps: assert property (p_w0_keeps)
      else $error("written zero changed status bit");

   property p_fixed;
      s_rd(hit_cmd) |=> CFG_RDATA_O[20] && CFG_RDATA_O[21] &&
         CFG_RDATA_O[26:25] == 2'h1 && CFG_RDATA_O[23] == B2B_SUPPORT;
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed status fields wrong");

   property p_mpar;
      (CE_I && MST_ACTIVE_I && perr_seen && cmd[6]) |=> stat_word[8];
   endproperty
   a_mpar: assert property (p_mpar)
      else $error("master parity flag not set");

   property p_mpar_gate;
      (CE_I && !cmd[6] && !stat_word[8]) |=> !stat_word[8];
   endproperty
   a_mpar_gate: assert property (p_mpar_gate)
      else $error("master parity flag set with bit 6 clear");

   property p_ta_sent;
      (CE_I && TGT_ABORT_SENT_I) |=> stat_word[11];
   endproperty
   a_ta_sent: assert property (p_ta_sent)
      else $error("target abort sent not recorded");

   property p_ta_seen;
      (CE_I && MST_TGT_ABORT_I) |=> stat_word[12];
   endproperty
   a_ta_seen: assert property (p_ta_seen)
      else $error("target abort seen not recorded");

   property p_ma_seen;
      (CE_I && MST_MASTER_ABORT_I) |=> stat_word[13];
   endproperty
   a_ma_seen: assert property (p_ma_seen)
      else $error("master abort not recorded");

   property p_syserr;
      (CE_I && SERR_REQ_I && cmd[8]) ##1 CE_I |=> stat_word[14];
   endproperty
   a_syserr: assert property (p_syserr)
      else $error("system error not recorded");

   property p_perr;
      (CE_I && PAR_ERR_DET_I && !cmd[6]) |=> stat_word[15];
   endproperty
   a_perr: assert property (p_perr)
      else $error("parity error not recorded");

   property p_unmapped;
      s_rd(!(hit_cmd || hit_class || hit_head || hit_type))
         |=> CFG_RDATA_O == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unimplemented location read nonzero");

   property p_flags_reset;
      $rose(NRST_I) |-> stat_word[15:11] == 5'h00 && !stat_word[8];
   endproperty
   a_flags_reset: assert property (p_flags_reset)
      else $error("status flags not clear after reset");

   property p_ack;
      CE_I |=> CFG_ACK_O == $past(CFG_SEL_I);
   endproperty
   a_ack: assert property (p_ack)
      else $error("configuration access not answered in one cycle");

   property p_mem;
      CE_I |=> MEM_DECODE_ENABLE_O == $past(cmd[1] && PM_D0_I);
   endproperty
   a_mem: assert property (p_mem)
      else $error("memory decode enable wrong");

   property p_serr_on;
      (CE_I && SERR_REQ_I && cmd[8]) |=> SYSERR_DRIVE_O;
   endproperty
   a_serr_on: assert property (p_serr_on)
      else $error("enabled system error request not driven");

   property p_wr_quiet;
      (CE_I && cfg_wr) |=> CFG_RDATA_O == 32'h00000000;
   endproperty
   a_wr_quiet: assert property (p_wr_quiet)
      else $error("write returned nonzero read data");

   // Frozen enable must hold command, status word with events, acknowledge and system error drive
   property p_freeze;
      !CE_I |=> $stable(cmd) && $stable(stat_word) && $stable(CFG_ACK_O) &&
         $stable(SYSERR_DRIVE_O);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state changed while clock enable low");
endmodule : pch_cfg_regs

// File: verilog/pch_pkg.sv
// Constants shared by the configuration header register files
package pch_pkg;
   localparam int          IDX_W        = 6;
   localparam logic [7:0]  OFS_CMD      = 8'h04;
   localparam logic [7:0]  OFS_CLASS    = 8'h09;
   localparam logic [7:0]  OFS_CAP_HEAD = 8'h34;
   localparam logic [7:0]  OFS_CAP_TYPE = 8'h50;
   localparam logic [7:0]  CAP_TYPE_VAL = 8'h01;
   localparam logic [23:0] CLASS_VAL    = 24'h020000;
   localparam logic [15:0] CMD_RESET    = 16'h0000;
   localparam logic [15:0] CMD_MASK     = 16'h0157;
   localparam logic [1:0]  SEL_SPEED    = 2'h1;
   localparam int          CMD_IO       = 0;
   localparam int          CMD_MEM      = 1;
   localparam int          CMD_MST      = 2;
   localparam int          CMD_MWI      = 4;
   localparam int          CMD_PAR      = 6;
   localparam int          CMD_SERR     = 8;
   localparam int          ST_CAP       = 4;
   localparam int          ST_66        = 5;
   localparam int          ST_B2B       = 7;
   localparam int          ST_SEL       = 9;
   localparam int          EVT_N        = 6;
   localparam int          EV_MPAR      = 0;
   localparam int          EV_TA_SENT   = 1;
   localparam int          EV_TA_SEEN   = 2;
   localparam int          EV_MA_SEEN   = 3;
   localparam int          EV_SERR      = 4;
   localparam int          EV_PERR      = 5;
   localparam int          EV_POS [EVT_N] = '{8, 11, 12, 13, 14, 15};
endpackage : pch_pkg

// File: verilog/pch_evt_if.sv
// Event set, clear and flag bundle between register file and flags
`timescale 1ns/10ps
interface pch_evt_if #(parameter int N = 6);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic [N-1:0] flag;
   modport owner (input set, input clr, output flag);
   modport user  (output set, output clr, input flag);
endinterface : pch_evt_if

// File: verilog/pch_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pch_pin_sync #(
   parameter int         W       = 1,
   parameter logic [0:0] RST_VAL = 1'b1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] val_o
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Refuse a width the per-bit loop cannot build
   if (W < 1) begin : g_bad_w
      $error("pch_pin_sync: W must be at least 1");
   end

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            s1[i]    <= RST_VAL[0];
            s2[i]    <= RST_VAL[0];
            s3[i]    <= RST_VAL[0];
            val_o[i] <= RST_VAL[0];
         end else if (ce_i) begin
            s1[i] <= pin_i[i];
            s2[i] <= s1[i];
            s3[i] <= s2[i];
            // Only second and third stages judge the change
            if (s2[i] == s3[i]) begin
               val_o[i] <= s3[i];
            end
         end
      end
   end
endmodule : pch_pin_sync

// File: verilog/pch_evt_flags.sv
// Sticky event flags, cleared by written ones
`timescale 1ns/10ps
module pch_evt_flags (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   pch_evt_if.owner  ev
);
   for (genvar i = 0; i < $bits(ev.flag); i++) begin : g_flag
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            ev.flag[i] <= 1'b0;
         end else if (ce_i) begin
            // Set beats a clear in the same cycle
            ev.flag[i] <= ev.set[i] | (ev.flag[i] & ~ev.clr[i]);
         end
      end
   end

   property p_set_wins;
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && ev.set[0]) |=> ev.flag[0];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event flag lost against a clear");
endmodule : pch_evt_flags

// File: verif/pch_host_model.sv
// Host bridge model issuing configuration reads and writes
`timescale 1ns/10ps
module pch_host_model (
   input  wire logic                      clk_i,
   input  wire logic                      ack_i,
   input  wire logic [31:0]               rdata_i,
   output logic                           sel_o,
   output logic                           wr_o,
   output logic      [pch_pkg::IDX_W+1:2] addr_o,
   output logic      [3:0]                be_o,
   output logic      [31:0]               wdata_o
);
   import pch_pkg::*;
   initial begin
      sel_o   = 1'b0;
      wr_o    = 1'b0;
      addr_o  = '0;
      be_o    = 4'h0;
      wdata_o = 32'h0;
   end
   // One access; raw lets a test write reserved command bits on purpose
   task automatic access(input logic w, input logic [IDX_W-1:0] a, input logic [3:0] b,
                         input logic [31:0] d, input logic raw, output logic [31:0] q);
      logic [31:0] dw;
      int          n;
      dw = d;
      if (!raw && a == 6'h01) begin
         dw[15:0] = d[15:0] & 16'h0157;
      end
      @(posedge clk_i);
      sel_o   <= 1'b1;
      wr_o    <= w;
      addr_o  <= a;
      be_o    <= b;
      wdata_o <= dw;
      @(posedge clk_i);
      sel_o   <= 1'b0;
      addr_o  <= ~a;
      // Released data never mirrors the last value
      wdata_o <= ~dw;
      n = 0;
      #1;
      while (ack_i !== 1'b1 && n < 8) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      q = (n == 8) ? 32'hX : rdata_i;
   endtask : access
endmodule : pch_host_model

// File: verif/pci_config_header_cmd_status_tb.sv
// Self-checking bench for the configuration command and status registers
`timescale 1ns/10ps
`define CHK(nm, ev, got) begin compares++; if ((got) !== (ev)) begin error_cnt++; \
   $display("unexpected %s expected %h seen %h", nm, ev, got); end end
module pci_config_header_cmd_status_tb;
   import pch_pkg::*;
   logic        clk, nrst, ce, d0, rom_win, mst_act, perr_n, serr_req;
   logic [3:0]  ev;
   logic        sel, wr, ack;
   logic [5:0]  addr;
   logic [3:0]  be;
   logic [31:0] wdata, rdata;
   logic        io_en, mem_en, rom_en, mst_en, mwi_en, par_rep, serr_drv;
   int          error_cnt, compares;

   pch_cfg_regs dut (.CORE_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .CFG_SEL_I(sel),
      .CFG_WR_I(wr), .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata), .PM_D0_I(d0),
      .ROM_WINDOW_ENABLE_I(rom_win), .MST_ACTIVE_I(mst_act), .PERR_N_I(perr_n),
      .TGT_ABORT_SENT_I(ev[0]), .MST_TGT_ABORT_I(ev[1]), .MST_MASTER_ABORT_I(ev[2]),
      .PAR_ERR_DET_I(ev[3]), .SERR_REQ_I(serr_req), .CFG_RDATA_O(rdata), .CFG_ACK_O(ack),
      .IO_DECODE_ENABLE_O(io_en), .MEM_DECODE_ENABLE_O(mem_en), .ROM_DECODE_ENABLE_O(rom_en),
      .MASTER_INITIATE_ENABLE_O(mst_en), .WRITE_INVALIDATE_PERMIT_O(mwi_en),
      .PARITY_REPORT_O(par_rep), .SYSERR_DRIVE_O(serr_drv));
   pch_host_model host (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .sel_o(sel), .wr_o(wr),
      .addr_o(addr), .be_o(be), .wdata_o(wdata));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic rd(input logic [5:0] idx, input logic [31:0] exv, input string nm);
      logic [31:0] q;
      host.access(1'b0, idx, 4'hF, 32'h0, 1'b0, q);
      `CHK(nm, exv, q)
   endtask : rd
   task automatic wrt(input logic [5:0] idx, input logic [3:0] b, input logic [31:0] d,
                      input logic raw);
      logic [31:0] q;
      host.access(1'b1, idx, b, d, raw, q);
      `CHK("write answer", 32'h0, q)
   endtask : wrt
   task automatic pulse(input logic [3:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 4'h0;
   endtask : pulse

   // Fixed status bits: list present, 66 MHz, medium select speed
   task automatic t_reset;
      `CHK("enables", 7'h00, {io_en, mem_en, rom_en, mst_en, mwi_en, par_rep, serr_drv})
      rd(6'h01, 32'h0230_0000, "cmd status");
      $display("t_reset done");
   endtask : t_reset
   task automatic t_ro;
      logic [5:0]  idx [4] = '{6'h02, 6'h0D, 6'h14, 6'h3F};
      logic [31:0] val [4] = '{32'h0200_0000, 32'h0000_0050, 32'h0000_0001, 32'h0};
      for (int i = 0; i < 4; i++) begin
         wrt(idx[i], 4'hF, 32'hFFFF_FFFF, 1'b1);
         rd(idx[i], val[i], "read-only word");
      end
      $display("t_ro done");
   endtask : t_ro
   task automatic t_cmd;
      wrt(6'h01, 4'h3, 32'h0000_FFFF, 1'b1);
      rd(6'h01, 32'h0230_0157, "cmd reserved");
      tick(1);
      `CHK("enables in d0", 5'h1F, {io_en, mem_en, rom_en, mst_en, mwi_en})
      @(posedge clk);
      d0 <= 1'b0;
      tick(2);
      `CHK("enables in d3", 5'h01, {io_en, mem_en, rom_en, mst_en, mwi_en})
      @(posedge clk);
      d0      <= 1'b1;
      rom_win <= 1'b0;
      tick(2);
      `CHK("rom window off", 5'h1B, {io_en, mem_en, rom_en, mst_en, mwi_en})
      @(posedge clk);
      rom_win <= 1'b1;
      wrt(6'h01, 4'h3, 32'h0, 1'b0);
      tick(1);
      `CHK("enables off", 5'h00, {io_en, mem_en, rom_en, mst_en, mwi_en})
      $display("t_cmd done");
   endtask : t_cmd
   task automatic t_errs;
      @(posedge clk);
      serr_req <= 1'b1;
      repeat (4) begin
         tick(1);
         `CHK("serr gated", 1'b0, serr_drv)
      end
      pulse(4'h8);
      #1;
      `CHK("parity gated", 1'b0, par_rep)
      rd(6'h01, 32'h8230_0000, "parity seen");
      wrt(6'h01, 4'h3, 32'h0000_0140, 1'b0);
      tick(3);
      `CHK("serr drive", 1'b1, serr_drv)
      pulse(4'h8);
      #1;
      `CHK("parity report", 1'b1, par_rep)
      tick(1);
      `CHK("parity pulse end", 1'b0, par_rep)
      @(posedge clk);
      serr_req <= 1'b0;
      rd(6'h01, 32'hC230_0140, "syserr flag");
      wrt(6'h01, 4'hC, 32'hC000_0000, 1'b0);
      rd(6'h01, 32'h0230_0140, "error flags cleared");
      $display("t_errs done");
   endtask : t_errs
   task automatic t_events;
      pulse(4'h7);
      rd(6'h01, 32'h3A30_0140, "abort flags");
      wrt(6'h01, 4'h8, 32'h1000_0000, 1'b0);
      rd(6'h01, 32'h2A30_0140, "one flag cleared");
      // Ones on the low status lane must not reach the flags
      wrt(6'h01, 4'h4, 32'h28FF_0000, 1'b0);
      rd(6'h01, 32'h2A30_0140, "flags kept");
      wrt(6'h01, 4'h8, 32'h2800_0000, 1'b0);
      rd(6'h01, 32'h0230_0140, "flags clear");
      $display("t_events done");
   endtask : t_events
   task automatic t_mpar;
      @(posedge clk);
      mst_act <= 1'b1;
      perr_n  <= 1'b0;
      tick(8);
      @(posedge clk);
      perr_n <= 1'b1;
      tick(6);
      rd(6'h01, 32'h0330_0140, "master parity");
      wrt(6'h01, 4'h8, 32'h0100_0000, 1'b0);
      wrt(6'h01, 4'h3, 32'h0000_0100, 1'b0);
      @(posedge clk);
      perr_n <= 1'b0;
      tick(8);
      @(posedge clk);
      perr_n  <= 1'b1;
      mst_act <= 1'b0;
      tick(6);
      rd(6'h01, 32'h0230_0100, "parity ignored");
      $display("t_mpar done");
   endtask : t_mpar
   // Frozen enable drops events; a mid-run reset clears all
   task automatic t_freeze;
      @(posedge clk);
      ce       <= 1'b0;
      serr_req <= 1'b1;
      pulse(4'h1);
      tick(2);
      `CHK("frozen serr", 1'b0, serr_drv)
      @(posedge clk);
      ce       <= 1'b1;
      serr_req <= 1'b0;
      rd(6'h01, 32'h0230_0100, "frozen event");
      pulse(4'h4);
      wrt(6'h01, 4'h3, 32'h0000_0017, 1'b0);
      @(posedge clk);
      nrst <= 1'b0;
      tick(2);
      `CHK("enables in reset", 5'h00, {io_en, mem_en, rom_en, mst_en, mwi_en})
      @(posedge clk);
      nrst <= 1'b1;
      tick(1);
      rd(6'h01, 32'h0230_0000, "after reset");
      $display("t_freeze done");
   endtask : t_freeze

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Whole sequence needs under two hundred cycles; allow ample margin
   initial begin
      #100000;
      error_cnt++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      nrst      = 1'b0;
      ce        = 1'b1;
      d0        = 1'b1;
      rom_win   = 1'b1;
      mst_act   = 1'b0;
      perr_n    = 1'b1;
      serr_req  = 1'b0;
      ev        = 4'h0;
      error_cnt = 0;
      compares  = 0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      tick(4);
      t_reset();
      t_ro();
      t_cmd();
      t_errs();
      t_events();
      t_mpar();
      t_freeze();
      complete_run();
   end
endmodule : pci_config_header_cmd_status_tb
